// ### common/mbx_dreg_if.sv
// Data register file access between the execution core and the store
`timescale 1ns/1ps
interface mbx_dreg_if;
    import mbx_pkg::*;
    logic [ADDR_W-1:0] rdAddr;
    logic [DATA_W-1:0] rdData;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [ADDR_W-1:0] peekAddr;
    logic [DATA_W-1:0] peekData;

    modport core (
        output rdAddr,
        input rdData,
        output wrEn,
        output wrAddr,
        output wrData,
        output peekAddr,
        input peekData
    );
    modport store (
        input rdAddr,
        output rdData,
        input wrEn,
        input wrAddr,
        input wrData,
        input peekAddr,
        output peekData
    );
endinterface

// ### common/mbx_pkg.sv
// Constants and types for the bit and call execution slice
package mbx_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W = 11;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned BIT_W = 3;
    localparam int unsigned REG_COUNT = 128;
    localparam int unsigned SP_W = 3;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned TBH_LSB = 0;
    localparam int unsigned TBH_MSB = 2;
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [SP_W-1:0] SP_STEP = 3'h1;
    localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
    localparam logic [DATA_W-1:0] PEEK_RESET = 8'h00;

    typedef enum logic [2:0] {
        OP_AND_IMMEDIATE = 3'h0,
        OP_BIT_SET = 3'h1,
        OP_BIT_TEST_SKIP_CLEAR = 3'h2,
        OP_INDIRECT_CALL = 3'h3,
        OP_REGISTER_CLEAR = 3'h4,
        OP_REGISTER_INVERT = 3'h5
    } mbx_op_e;

    typedef enum logic [1:0] {
        ST_ISSUE = 2'b01,
        ST_SECOND = 2'b10
    } mbx_state_e;
endpackage

// ### core/mbx_exec.sv
// Execution slice: AND-immediate, bit set, bit test skip, call, clear, invert
`timescale 1ns/1ps
module mbx_exec
    import mbx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic opValid,
    input mbx_op_e opCode,
    input wire logic [DATA_W-1:0] opImm,
    input wire logic [ADDR_W-1:0] opAddr,
    input wire logic [BIT_W-1:0] opBit,
    input wire logic opDest,
    input wire logic [DATA_W-1:0] tableHigh,
    input wire logic [ADDR_W-1:0] peekAddr,
    output logic opReady,
    output logic [DATA_W-1:0] workReg,
    output logic zeroFlag,
    output logic [PC_W-1:0] pc,
    output logic [SP_W-1:0] stackPtr,
    output logic [PC_W-1:0] stackTop,
    output logic skipNop,
    output logic [DATA_W-1:0] peekData
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rstMeta;
    logic rstSyncN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file
    mbx_dreg_if dr ();

    mbx_regfile u_regfile (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .dr(dr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode
    mbx_state_e state;
    mbx_state_e next_state;
    logic accept;
    logic isAnd;
    logic isSet;
    logic isSkip;
    logic isCall;
    logic isClear;
    logic isInvert;
    logic [DATA_W-1:0] regVal;
    logic [DATA_W-1:0] bitMask;
    logic [DATA_W-1:0] andResult;
    logic [DATA_W-1:0] setResult;
    logic [DATA_W-1:0] invResult;
    logic bitClear;
    logic takeSkip;
    logic [PC_W-1:0] pcPlusOne;
    logic [PC_W-1:0] callTarget;
    logic [SP_W-1:0] spBelow;

    assign accept = opValid && opReady;
    assign isAnd = accept && (opCode == OP_AND_IMMEDIATE);
    assign isSet = accept && (opCode == OP_BIT_SET);
    assign isSkip = accept && (opCode == OP_BIT_TEST_SKIP_CLEAR);
    assign isCall = accept && (opCode == OP_INDIRECT_CALL);
    assign isClear = accept && (opCode == OP_REGISTER_CLEAR);
    assign isInvert = accept && (opCode == OP_REGISTER_INVERT);

    assign dr.rdAddr = opAddr;
    assign dr.peekAddr = peekAddr;
    assign regVal = dr.rdData;
    assign bitMask = BIT_ONE << opBit;
    assign andResult = workReg & opImm;
    assign setResult = regVal | bitMask;
    assign invResult = ~regVal;
    assign bitClear = (regVal & bitMask) == CLEAR_VALUE;
    assign takeSkip = isSkip && bitClear;
    assign pcPlusOne = pc + PC_STEP;
    assign callTarget = {tableHigh[TBH_MSB:TBH_LSB], workReg};
    assign spBelow = stackPtr - SP_STEP;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    assign dr.wrEn = isSet || isClear || (isInvert && opDest);
    assign dr.wrAddr = opAddr;
    assign dr.wrData = isSet ? setResult :
                       isClear ? CLEAR_VALUE : invResult;

    ////////////////////////////////////////////////////////////////////////
    // Work register and zero flag
    logic [DATA_W-1:0] next_workReg;
    logic next_zeroFlag;

    assign next_workReg = isAnd ? andResult :
                          (isInvert && !opDest) ? invResult : workReg;
    assign next_zeroFlag = isAnd ? (andResult == CLEAR_VALUE) :
                           isClear ? 1'b1 :
                           isInvert ? (invResult == CLEAR_VALUE) :
                           zeroFlag;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            workReg <= WORK_RESET;
            zeroFlag <= ZERO_RESET;
        end else begin
            workReg <= next_workReg;
            zeroFlag <= next_zeroFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and program counter
    logic [PC_W-1:0] next_pc;
    logic next_skipNop;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_ISSUE: begin
                if (isCall || takeSkip) begin
                    next_state = ST_SECOND;
                end
            end
            ST_SECOND: begin
                next_state = ST_ISSUE;
            end
            default: begin
                next_state = ST_ISSUE;
            end
        endcase
    end

    // Skipped slot advances past the discarded instruction
    assign next_pc = isCall ? callTarget :
                     accept ? pcPlusOne :
                     skipNop ? pcPlusOne : pc;
    assign next_skipNop = takeSkip;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state <= ST_ISSUE;
            opReady <= 1'b0;
            pc <= PC_RESET;
            skipNop <= 1'b0;
        end else begin
            state <= next_state;
            opReady <= (next_state == ST_ISSUE);
            pc <= next_pc;
            skipNop <= next_skipNop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hardware stack
    logic [PC_W-1:0] stack [STACK_DEPTH];

    always_ff @(posedge clk) begin
        if (isCall) begin
            stack[stackPtr] <= pcPlusOne;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stackPtr <= SP_RESET;
            stackTop <= PC_RESET;
            peekData <= PEEK_RESET;
        end else begin
            stackPtr <= isCall ? stackPtr + SP_STEP : stackPtr;
            stackTop <= stack[spBelow];
            peekData <= dr.peekData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncN);

    property p_and_immediate;
        isAnd |=> workReg == $past(workReg & opImm) &&
                  zeroFlag == (workReg == CLEAR_VALUE) && opReady;
    endproperty
    a_and_immediate: assert property (p_and_immediate)
        else $error("and immediate result or zero wrong");

    property p_bit_set;
        isSet |-> dr.wrEn && dr.wrData == (dr.rdData | (BIT_ONE << opBit))
                  ##1 $stable(zeroFlag) && $stable(workReg) && opReady;
    endproperty
    a_bit_set: assert property (p_bit_set)
        else $error("bit set write or flags wrong");

    property p_skip_taken;
        takeSkip |=> !opReady && skipNop
                     ##1 opReady && pc == $past(pc, 2) + 11'h002;
    endproperty
    a_skip_taken: assert property (p_skip_taken)
        else $error("skip did not discard next instruction");

    property p_skip_not_taken;
        (isSkip && !bitClear) |=> opReady && !skipNop &&
                                  pc == $past(pc) + PC_STEP &&
                                  $stable(zeroFlag);
    endproperty
    a_skip_not_taken: assert property (p_skip_not_taken)
        else $error("untaken skip took more than one cycle");

    property p_call_push;
        isCall |=> !opReady && stackPtr == $past(stackPtr) + SP_STEP &&
                   $stable(zeroFlag)
                   ##1 opReady && stackTop == $past(pc, 2) + PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call push or length wrong");

    property p_call_target;
        isCall |=> pc == {$past(tableHigh[TBH_MSB:TBH_LSB]), $past(workReg)};
    endproperty
    a_call_target: assert property (p_call_target)
        else $error("call target wrong");

    property p_clear;
        isClear |-> dr.wrEn && dr.wrData == CLEAR_VALUE
                    ##1 zeroFlag && opReady;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero register or set zero");

    property p_invert_work;
        (isInvert && !opDest) |-> !dr.wrEn
            ##1 workReg == ~$past(dr.rdData) &&
                zeroFlag == (workReg == CLEAR_VALUE);
    endproperty
    a_invert_work: assert property (p_invert_work)
        else $error("invert into work register wrong");

    property p_invert_reg;
        (isInvert && opDest) |-> dr.wrEn && dr.wrData == ~dr.rdData
            ##1 $stable(workReg) && zeroFlag == ($past(dr.rdData) == 8'hFF);
    endproperty
    a_invert_reg: assert property (p_invert_reg)
        else $error("invert into register wrong");

    c_skip: cover property (takeSkip ##2 accept);
    c_call: cover property (isCall ##2 isCall);
    c_clear_then_and: cover property (isClear ##1 isAnd);
    c_invert_zero: cover property (isInvert && invResult == CLEAR_VALUE);
endmodule // mbx_exec

// ### core/mbx_regfile.sv
// Data register array with one read, one write and a registered peek port
`timescale 1ns/1ps
module mbx_regfile
    import mbx_pkg::*;
(
    input wire logic clk,
    input wire logic rstSyncN,
    mbx_dreg_if.store dr
);
    logic [DATA_W-1:0] mem [REG_COUNT];
    logic [DATA_W-1:0] peek;

    assign dr.rdData = mem[dr.rdAddr];
    assign dr.peekData = peek;

    always_ff @(posedge clk) begin
        if (dr.wrEn) begin
            mem[dr.wrAddr] <= dr.wrData;
        end
    end

    // Peek shows the stored value one cycle after the address
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            peek <= PEEK_RESET;
        end else begin
            peek <= mem[dr.peekAddr];
        end
    end
endmodule // mbx_regfile

// ### verif/mbx_exec_tb.sv
// Self-checking bench for the bit and call execution slice
`timescale 1ns/1ps
module mbx_exec_tb
    import mbx_pkg::*;
;
    logic clk;
    logic rst_n;
    logic opValid;
    mbx_op_e opCode;
    logic [DATA_W-1:0] opImm;
    logic [ADDR_W-1:0] opAddr;
    logic [BIT_W-1:0] opBit;
    logic opDest;
    logic [DATA_W-1:0] tableHigh;
    logic [ADDR_W-1:0] peekAddr;
    logic opReady;
    logic [DATA_W-1:0] workReg;
    logic zeroFlag;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] stackPtr;
    logic [PC_W-1:0] stackTop;
    logic skipNop;
    logic [DATA_W-1:0] peekData;
    int errCount;
    int numChecks;
    int mRegs [REG_COUNT];
    int mStk [STACK_DEPTH];
    int mW;
    int mZ;
    int mPc;
    int mSp;
    int addrs [8];

    mbx_exec uut (
        .clk(clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
        .opImm(opImm), .opAddr(opAddr), .opBit(opBit), .opDest(opDest),
        .tableHigh(tableHigh), .peekAddr(peekAddr), .opReady(opReady),
        .workReg(workReg), .zeroFlag(zeroFlag), .pc(pc),
        .stackPtr(stackPtr), .stackTop(stackTop), .skipNop(skipNop),
        .peekData(peekData)
    );

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrapUp;
        if (errCount == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic issue(input mbx_op_e op, input int imm, input int a,
                         input int b, input int d, input int th);
        int n;
        int r;
        logic taken;
        n = 0;
        // Busy cycles: a clear offered here must be ignored
        while (opReady !== 1'b1) begin
            opValid = 1'b1;
            opCode = OP_REGISTER_CLEAR;
            opAddr = a[ADDR_W-1:0];
            @(posedge clk);
            #1;
            n++;
            if (n == 20) begin
                errCount++;
                wrapUp();
            end
        end
        opValid = 1'b1;
        opCode = op;
        opImm = imm[DATA_W-1:0];
        opAddr = a[ADDR_W-1:0];
        opBit = b[BIT_W-1:0];
        opDest = d[0];
        tableHigh = th[DATA_W-1:0];
        taken = 1'b0;
        r = (~mRegs[a]) & 'hFF;
        mPc = (mPc + 1) & 'h7FF;
        case (op)
            OP_AND_IMMEDIATE: begin
                mW = mW & imm;
                mZ = (mW == 0);
            end
            OP_BIT_SET: mRegs[a] = mRegs[a] | (1 << b);
            OP_BIT_TEST_SKIP_CLEAR: taken = ((mRegs[a] >> b) & 1) == 0;
            OP_INDIRECT_CALL: begin
                mStk[mSp] = mPc;
                mSp = (mSp + 1) % STACK_DEPTH;
                mPc = ((th & 7) << 8) | mW;
            end
            OP_REGISTER_CLEAR: begin
                mRegs[a] = 0;
                mZ = 1;
            end
            default: begin
                if (d == 0) mW = r;
                else mRegs[a] = r;
                mZ = (r == 0);
            end
        endcase
        @(posedge clk);
        #1;
        chk("workReg", workReg, mW);
        chk("zeroFlag", zeroFlag, mZ);
        chk("pc", pc, mPc);
        chk("stackPtr", stackPtr, mSp);
        chk("opReady", opReady, !(taken || op == OP_INDIRECT_CALL));
        chk("skipNop", skipNop, taken);
        if (taken || op == OP_INDIRECT_CALL) begin
            opCode = OP_REGISTER_CLEAR;
            @(posedge clk);
            #1;
            if (taken) mPc = (mPc + 1) & 'h7FF;
            chk("pc", pc, mPc);
            chk("opReady", opReady, 1'b1);
            chk("skipNop", skipNop, 1'b0);
            if (op == OP_INDIRECT_CALL) begin
                chk("stackTop", stackTop, mStk[(mSp + 7) % 8]);
            end
        end
    endtask

    task automatic peek(input int a);
        opValid = 1'b0;
        peekAddr = a[ADDR_W-1:0];
        repeat (2) @(posedge clk);
        #1;
        chk("peekData", peekData, mRegs[a]);
    endtask

    task automatic setReg(input int a, input int v);
        issue(OP_REGISTER_CLEAR, 0, a, 0, 0, 0);
        for (int b = 0; b < 8; b++) begin
            if ((v >> b) & 1) issue(OP_BIT_SET, 0, a, b, 0, 0);
        end
        peek(a);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        opValid = 1'b0;
        opCode = OP_AND_IMMEDIATE;
        opImm = 8'h00;
        opAddr = 7'h00;
        opBit = 3'h0;
        opDest = 1'b0;
        tableHigh = 8'h00;
        peekAddr = 7'h00;
        errCount = 0;
        numChecks = 0;
        mW = 0;
        mZ = 0;
        mPc = 0;
        mSp = 0;
        void'($urandom(99));
        repeat (3) @(posedge clk);
        #1;
        chk("workReg", workReg, WORK_RESET);
        chk("pc", pc, PC_RESET);
        chk("opReady", opReady, 1'b0);
        rst_n = 1'b1;
        addrs[0] = 0;
        addrs[1] = 127;
        for (int i = 2; i < 8; i++) addrs[i] = $urandom_range(1, 126);
        for (int i = 0; i < 8; i++) setReg(addrs[i], $urandom_range(0, 255));
        // Work register 5A, then AND with AF, then AND with zero
        setReg(addrs[0], 'hA5);
        issue(OP_REGISTER_INVERT, 0, addrs[0], 0, 0, 0);
        issue(OP_AND_IMMEDIATE, 'hAF, 0, 0, 0, 0);
        issue(OP_AND_IMMEDIATE, 'h00, 0, 0, 0, 0);
        for (int b = 0; b < 8; b++) begin
            issue(OP_BIT_TEST_SKIP_CLEAR, 0, addrs[0], b, 0, 0);
        end
        for (int i = 0; i < 9; i++) begin
            issue(OP_INDIRECT_CALL, 0, 0, 0, 0, $urandom_range(0, 255));
        end
        for (int i = 0; i < 300; i++) begin
            int a;
            a = addrs[$urandom_range(0, 7)];
            issue(mbx_op_e'($urandom_range(0, 5)), $urandom_range(0, 255), a,
                  $urandom_range(0, 7), $urandom_range(0, 1),
                  $urandom_range(0, 255));
            if (i % 4 == 3) peek(a);
        end
        peek(addrs[1]);
        wrapUp();
    end
endmodule // mbx_exec_tb
